// *** pwmu_pkg.sv ***
// Purpose: Shared constants for the multi-generator PWM unit
// Assumes: One core clock, active-low reset
// Notes:   Widths fixed at the full four-generator build
`default_nettype none
package pwmu_pkg;
	localparam int        PWMU_GEN_MAX     = 4;
	localparam int        PWMU_OUT_MAX     = 2 * PWMU_GEN_MAX;
	localparam int        PWMU_CNT_W       = 16;
	localparam int        PWMU_INT_W       = PWMU_GEN_MAX + 1;
	localparam int        PWMU_FAULT_BIT   = PWMU_GEN_MAX;
	localparam logic [15:0] PWMU_CNT_RESET = 16'h0000;
	localparam logic [15:0] PWMU_CNT_ONE   = 16'h0001;
	localparam logic [15:0] PWMU_CNT_FULL  = 16'hffff;
	localparam logic [1:0]  PWMU_SYNC_RST  = 2'h0;
	localparam logic [7:0]  PWMU_OUT_RESET = 8'h00;
	localparam logic [4:0]  PWMU_INT_RESET = 5'h00;
endpackage
`default_nettype wire

// *** pwmu_gen.sv ***
// Purpose: One generator: counter, two comparators, waveform, dead band
// Assumes: Reset already synchronised; config from core-clock logic
// Notes:   All outputs are registered
`timescale 1ns/10ps
`default_nettype none
module pwmu_gen
	import pwmu_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_enable,
	input  wire logic                  i_updown,
	input  wire logic                  i_sync_mode,
	input  wire logic                  i_sync_event,
	input  wire logic                  i_dbg_pause,
	input  wire logic                  i_dbg_halt,
	input  wire logic                  i_db_enable,
	input  wire logic [PWMU_CNT_W-1:0] i_load,
	input  wire logic [PWMU_CNT_W-1:0] i_cmp_a,
	input  wire logic [PWMU_CNT_W-1:0] i_cmp_b,
	input  wire logic [PWMU_CNT_W-1:0] i_db_rise,
	input  wire logic [PWMU_CNT_W-1:0] i_db_fall,
	output logic                       o_first_wave_output,
	output logic                       o_second_wave_output,
	output logic                       o_int,
	output logic                       o_trig
);
	logic [PWMU_CNT_W-1:0] cnt_reg;
	logic                  up_reg;
	logic [PWMU_CNT_W-1:0] load_reg;
	logic [PWMU_CNT_W-1:0] cmpa_reg;
	logic [PWMU_CNT_W-1:0] cmpb_reg;
	logic                  pend_reg;
	logic [PWMU_CNT_W-1:0] db_cnt_reg;
	logic                  a_prev_reg;
	logic                  at_zero;
	logic                  hold;
	logic                  apply;
	logic                  a_raw;
	logic                  b_raw;

	assign at_zero = (cnt_reg == PWMU_CNT_RESET);
	// Pause only once the count has run down to zero
	assign hold    = i_dbg_halt && i_dbg_pause && at_zero;
	assign apply   = at_zero && (!i_sync_mode || pend_reg || i_sync_event);
	assign a_raw   = i_updown ? (cnt_reg < cmpa_reg) : (cnt_reg >= cmpa_reg);
	assign b_raw   = i_updown ? (cnt_reg < cmpb_reg) : (cnt_reg >= cmpb_reg);

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pend_reg <= 1'b0;
		else if (i_sync_event && !at_zero)
			pend_reg <= 1'b1;
		else if (apply)
			pend_reg <= 1'b0;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			load_reg <= PWMU_CNT_RESET;
			cmpa_reg <= PWMU_CNT_RESET;
			cmpb_reg <= PWMU_CNT_RESET;
		end
		else if (apply || !i_enable)
		begin
			load_reg <= i_load;
			cmpa_reg <= i_cmp_a;
			cmpb_reg <= i_cmp_b;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_reg <= PWMU_CNT_RESET;
			up_reg  <= 1'b1;
		end
		else if (!i_enable)
		begin
			cnt_reg <= PWMU_CNT_RESET;
			up_reg  <= 1'b1;
		end
		else if (hold)
			cnt_reg <= cnt_reg;
		else if (!i_updown)
			cnt_reg <= at_zero ? load_reg : cnt_reg - PWMU_CNT_ONE;
		else if (up_reg)
		begin
			// Turn at the load value, center-aligned
			if (cnt_reg >= load_reg)
			begin
				up_reg  <= 1'b0;
				cnt_reg <= at_zero ? cnt_reg : cnt_reg - PWMU_CNT_ONE;
			end
			else
				cnt_reg <= cnt_reg + PWMU_CNT_ONE;
		end
		else if (cnt_reg == PWMU_CNT_ONE || at_zero)
		begin
			up_reg  <= 1'b1;
			cnt_reg <= PWMU_CNT_RESET;
		end
		else
			cnt_reg <= cnt_reg - PWMU_CNT_ONE;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_int  <= 1'b0;
			o_trig <= 1'b0;
		end
		else
		begin
			o_int  <= i_enable && at_zero && !hold;
			o_trig <= i_enable && at_zero && !hold;
		end
	end

	// Edge timer measured from each edge of the first output
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			a_prev_reg <= 1'b0;
			db_cnt_reg <= PWMU_CNT_RESET;
		end
		else
		begin
			a_prev_reg <= a_raw;
			if (a_raw != a_prev_reg)
				db_cnt_reg <= PWMU_CNT_ONE;
			else if (db_cnt_reg != PWMU_CNT_FULL)
				db_cnt_reg <= db_cnt_reg + PWMU_CNT_ONE;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_first_wave_output  <= 1'b0;
			o_second_wave_output <= 1'b0;
		end
		else if (!i_enable)
		begin
			o_first_wave_output  <= 1'b0;
			o_second_wave_output <= 1'b0;
		end
		else if (i_db_enable)
		begin
			// Second output rebuilt from the first, with gaps
			o_first_wave_output  <= a_raw && a_raw == a_prev_reg
				&& db_cnt_reg >= i_db_rise;
			o_second_wave_output <= !a_raw && a_raw == a_prev_reg
				&& db_cnt_reg >= i_db_fall;
		end
		else
		begin
			o_first_wave_output  <= a_raw;
			o_second_wave_output <= b_raw;
		end
	end

	default clocking gen_cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	cnt_disabled_a: assert property (!i_enable |=> cnt_reg == PWMU_CNT_RESET)
		else $error("counter not cleared while disabled");
	down_reload_a: assert property (i_enable && !i_updown && at_zero && !hold
		&& $stable(i_updown) |=> cnt_reg == $past(load_reg))
		else $error("down count did not reload");
	pause_hold_a: assert property (i_enable && hold ##1 i_enable
		|-> $stable(cnt_reg))
		else $error("paused counter moved");
	update_zero_a: assert property (i_enable && !at_zero
		|=> load_reg == $past(load_reg))
		else $error("period changed away from zero");
	db_gap_a: assert property (i_enable && i_db_enable ##1 i_enable
		&& i_db_enable |-> !(o_first_wave_output && o_second_wave_output))
		else $error("coupled outputs high together");
	trig_int_a: assert property (o_trig == o_int)
		else $error("trigger and interrupt disagree");
	updown_c: cover property (i_enable && i_updown && !up_reg ##1 at_zero);
	db_c: cover property (i_db_enable && $rose(o_second_wave_output));
endmodule
`default_nettype wire

// *** pwmu_top.sv ***
// Purpose: PWM unit: generators plus shared output control block
// Assumes: Config and debug halt come from core-clock logic
// Notes:   Fault pin is asynchronous and synchronised here
`timescale 1ns/10ps
`default_nettype none
module pwmu_top
	import pwmu_pkg::*;
#(
	parameter int GEN_COUNT = 4
)
(
	input  wire logic                    i_core_clk,
	input  wire logic                    i_reset_n,
	input  wire logic [PWMU_GEN_MAX-1:0] i_gen_enable,
	input  wire logic [PWMU_GEN_MAX-1:0] i_count_updown,
	input  wire logic [PWMU_GEN_MAX-1:0] i_sync_mode,
	input  wire logic [PWMU_GEN_MAX-1:0] i_sync_update,
	input  wire logic [PWMU_GEN_MAX-1:0] i_dbg_pause,
	input  wire logic [PWMU_GEN_MAX-1:0] i_db_enable,
	input  wire logic [PWMU_GEN_MAX-1:0][PWMU_CNT_W-1:0] i_load,
	input  wire logic [PWMU_GEN_MAX-1:0][PWMU_CNT_W-1:0] i_cmp_a,
	input  wire logic [PWMU_GEN_MAX-1:0][PWMU_CNT_W-1:0] i_cmp_b,
	input  wire logic [PWMU_GEN_MAX-1:0][PWMU_CNT_W-1:0] i_db_rise,
	input  wire logic [PWMU_GEN_MAX-1:0][PWMU_CNT_W-1:0] i_db_fall,
	input  wire logic                    i_dbg_halt,
	input  wire logic                    i_fault_pin,
	input  wire logic                    i_fault_minper_en,
	input  wire logic [PWMU_CNT_W-1:0]   i_fault_minper,
	input  wire logic [PWMU_OUT_MAX-1:0] i_out_enable,
	input  wire logic [PWMU_OUT_MAX-1:0] i_out_invert,
	input  wire logic [PWMU_OUT_MAX-1:0] i_fault_suppress,
	input  wire logic [PWMU_OUT_MAX-1:0] i_fault_level,
	output logic      [PWMU_OUT_MAX-1:0] o_wave_out,
	output logic      [PWMU_GEN_MAX-1:0] o_gen_int,
	output logic      [PWMU_GEN_MAX-1:0] o_gen_trig,
	output logic                         o_fault_int,
	output logic      [PWMU_INT_W-1:0]   o_int_status
);
	logic [1:0]              rst_sync_reg;
	logic                    rst_n;
	logic [1:0]              fault_sync_reg;
	logic                    fault_in;
	logic [PWMU_CNT_W-1:0]   minper_reg;
	logic                    fault_act;
	logic [PWMU_OUT_MAX-1:0] raw_wave;
	logic [PWMU_GEN_MAX-1:0] gen_int;
	logic [PWMU_GEN_MAX-1:0] gen_trig;

	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rst_sync_reg <= PWMU_SYNC_RST;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Fault pin is asynchronous; only the second stage is read
	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
			fault_sync_reg <= PWMU_SYNC_RST;
		else
			fault_sync_reg <= {fault_sync_reg[0], i_fault_pin};
	end
	assign fault_in = fault_sync_reg[1];

	genvar g;
	generate
		for (g = 0; g < PWMU_GEN_MAX; g++)
		begin : gen_blk
			if (g < GEN_COUNT)
			begin : live
				pwmu_gen u_gen (
					.i_core_clk           (i_core_clk),
					.i_rst_n              (rst_n),
					.i_enable             (i_gen_enable[g]),
					.i_updown             (i_count_updown[g]),
					.i_sync_mode          (i_sync_mode[g]),
					.i_sync_event         (i_sync_update[g]),
					.i_dbg_pause          (i_dbg_pause[g]),
					.i_dbg_halt           (i_dbg_halt),
					.i_db_enable          (i_db_enable[g]),
					.i_load               (i_load[g]),
					.i_cmp_a              (i_cmp_a[g]),
					.i_cmp_b              (i_cmp_b[g]),
					.i_db_rise            (i_db_rise[g]),
					.i_db_fall            (i_db_fall[g]),
					.o_first_wave_output  (raw_wave[2*g]),
					.o_second_wave_output (raw_wave[2*g+1]),
					.o_int                (gen_int[g]),
					.o_trig               (gen_trig[g])
				);
			end
			else
			begin : absent
				// Three-generator build: outputs six and seven stay low
				assign raw_wave[2*g]   = 1'b0;
				assign raw_wave[2*g+1] = 1'b0;
				assign gen_int[g]      = 1'b0;
				assign gen_trig[g]     = 1'b0;
			end
		end
	endgenerate

	// Minimum fault period timer, restarted while the pin is active
	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
			minper_reg <= PWMU_CNT_RESET;
		else if (fault_in && i_fault_minper_en)
			minper_reg <= i_fault_minper;
		else if (minper_reg != PWMU_CNT_RESET)
			minper_reg <= minper_reg - PWMU_CNT_ONE;
	end
	assign fault_act = fault_in || (minper_reg != PWMU_CNT_RESET);

	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_wave_out <= PWMU_OUT_RESET;
		else
			for (int i = 0; i < PWMU_OUT_MAX; i++)
				if (!i_out_enable[i])
					o_wave_out[i] <= 1'b0;
				else if (fault_act && i_fault_suppress[i])
					o_wave_out[i] <= i_fault_level[i];
				else
					o_wave_out[i] <= raw_wave[i] ^ i_out_invert[i];
	end

	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_gen_int    <= PWMU_OUT_RESET[PWMU_GEN_MAX-1:0];
			o_gen_trig   <= PWMU_OUT_RESET[PWMU_GEN_MAX-1:0];
			o_fault_int  <= 1'b0;
			o_int_status <= PWMU_INT_RESET;
		end
		else
		begin
			o_gen_int    <= gen_int;
			o_gen_trig   <= gen_trig;
			o_fault_int  <= fault_act;
			o_int_status <= {fault_act, gen_int};
		end
	end

	default clocking top_cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	out_gate_a: assert property (!i_out_enable[0] |=> !o_wave_out[0])
		else $error("disabled output not gated");
	out_invert_a: assert property (i_out_enable[1] && !fault_act
		|=> o_wave_out[1] == ($past(raw_wave[1]) ^ $past(i_out_invert[1])))
		else $error("polarity control wrong");
	fault_force_a: assert property (fault_act && i_out_enable[2]
		&& i_fault_suppress[2] |=> o_wave_out[2] == $past(i_fault_level[2]))
		else $error("fault level not driven");
	minper_hold_a: assert property (fault_in && i_fault_minper_en
		&& i_fault_minper > 16'h0003 ##1 !fault_in
		|-> ##1 o_fault_int [*2])
		else $error("fault dropped before minimum period");
	fault_drop_a: assert property (!fault_act ##1 !fault_act |=> !o_fault_int)
		else $error("fault interrupt without fault");
	status_map_a: assert property (o_int_status[PWMU_FAULT_BIT] == o_fault_int
		&& o_int_status[PWMU_GEN_MAX-1:0] == o_gen_int)
		else $error("interrupt status mismatched");
	fault_c: cover property ($rose(o_fault_int) ##[1:20] $fell(o_fault_int));
	wave_c: cover property ($rose(o_wave_out[0]) ##[1:100] $fell(o_wave_out[0]));
	sync_c: cover property (i_sync_mode[1] && i_sync_update[1]);
endmodule
`default_nettype wire

// *** pwmu_load_model.sv ***
// Purpose: Load on the wave pins plus a fault source for the unit
// Assumes: Pins are sampled on the core clock
// Notes:   Counts cycles where a watched pair is on at once
`timescale 1ns/10ps
`default_nettype none
module pwmu_load_model
	import pwmu_pkg::*;
(
	input  wire logic                    i_core_clk,
	input  wire logic [PWMU_OUT_MAX-1:0] i_wave_out,
	input  wire logic [PWMU_GEN_MAX-1:0] i_pair_watch,
	input  wire logic                    i_trip,
	output logic                         o_fault_pin,
	output var int                       o_overlaps
);
	// Overcurrent sense behaves as a plain level
	assign o_fault_pin = i_trip;
	logic [PWMU_GEN_MAX-1:0] watch_d1, watch_d2; // Pins lag two edges
	initial o_overlaps = 0;
	// Both switches of a leg on would short the supply
	always @(posedge i_core_clk)
	begin
		watch_d1 <= i_pair_watch;
		watch_d2 <= watch_d1;
		for (int g = 0; g < PWMU_GEN_MAX; g++)
			if (i_pair_watch[g] && watch_d1[g] && watch_d2[g]
				&& i_wave_out[2*g] === 1'b1 && i_wave_out[2*g+1] === 1'b1)
				o_overlaps <= o_overlaps + 1;
	end
endmodule
`default_nettype wire

// *** pwmu_top_tb.sv ***
// Purpose: Self-checking bench for the PWM unit
// Assumes: Inputs change on the falling clock edge
// Notes:   Waveforms are judged by counts over whole periods
`timescale 1ns/10ps
`default_nettype none
module pwmu_top_tb
	import pwmu_pkg::*;
;
	logic clk, rst_n, halt, trip, mp_en, f_pin;
	logic [3:0] en, ud, sm, su, pz, db;
	logic [3:0][15:0] ld, ca, cb, dr, df;
	logic [15:0] mp;
	logic [7:0] oe, inv, fs, fl, wave;
	logic [3:0] gint, gtrig;
	logic fint;
	logic [4:0] stat;
	int n_mismatch, n_tests, ovl, nf;
	int hi[8];
	int ni[4];
	int nt[4];
	pwmu_top #(.GEN_COUNT(4)) uut (.i_core_clk(clk), .i_reset_n(rst_n),
		.i_gen_enable(en), .i_count_updown(ud), .i_sync_mode(sm),
		.i_sync_update(su), .i_dbg_pause(pz), .i_db_enable(db), .i_load(ld),
		.i_cmp_a(ca), .i_cmp_b(cb), .i_db_rise(dr), .i_db_fall(df),
		.i_dbg_halt(halt), .i_fault_pin(f_pin), .i_fault_minper_en(mp_en),
		.i_fault_minper(mp), .i_out_enable(oe), .i_out_invert(inv),
		.i_fault_suppress(fs), .i_fault_level(fl), .o_wave_out(wave),
		.o_gen_int(gint), .o_gen_trig(gtrig), .o_fault_int(fint),
		.o_int_status(stat));
	pwmu_load_model load (.i_core_clk(clk), .i_wave_out(wave),
		.i_pair_watch(db), .i_trip(trip), .o_fault_pin(f_pin),
		.o_overlaps(ovl));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input int exp, input int got);
		n_tests++;
		if (got != exp)
		begin
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
			n_mismatch++;
		end
	endtask
	// Counts highs over n cycles, sampled at the falling edge
	task automatic run(input int n);
		hi = '{default: 0};
		ni = '{default: 0};
		nt = '{default: 0};
		nf = 0;
		repeat (n) @(negedge clk)
		begin
			for (int i = 0; i < 8; i++)
				hi[i] += int'(wave[i] === 1'b1);
			for (int g = 0; g < 4; g++)
			begin
				ni[g] += int'(gint[g] === 1'b1);
				nt[g] += int'(gtrig[g] === 1'b1);
			end
			nf += int'(fint === 1'b1);
		end
	endtask
	task automatic gen(input int g, input logic u, input logic [15:0] l,
		input logic [15:0] a, input logic [15:0] b);
		@(negedge clk);
		ud[g] = u;
		ld[g] = l;
		ca[g] = a;
		cb[g] = b;
	endtask
	initial
	begin
		#1ms;
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		{rst_n, halt, trip, mp_en, en, ud, sm, su, pz, db} = '0;
		{ld, ca, cb, dr, df, mp, oe, inv, fs, fl} = '0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		run(20);
		chk("outputs after reset", 0, hi.sum() + ni.sum());
		oe = 8'hff;
		for (int g = 0; g < 4; g++)
			gen(g, 1'b0, 16'(3 + g), 16'h0002, 16'h0001);
		en = 4'hf;
		repeat (20) @(negedge clk);
		for (int g = 0; g < 4; g++)
		begin
			run((4 + g) * 10);
			chk("gen int pulses", 10, ni[g]);
			chk("gen trig pulses", 10, nt[g]);
			chk("first out high", (g + 2) * 10, hi[2*g]);
			chk("second out high", (g + 3) * 10, hi[2*g+1]);
		end
		gen(0, 1'b1, 16'h0004, 16'h0002, 16'h0001);
		repeat (20) @(negedge clk);
		run(80);
		chk("updown int pulses", 10, ni[0]);
		chk("updown high", 30, hi[0]);
		inv[0] = 1'b1;
		repeat (4) @(negedge clk);
		run(80);
		chk("inverted high", 50, hi[0]);
		oe[0] = 1'b0;
		repeat (4) @(negedge clk);
		run(80);
		chk("gated high", 0, hi[0]);
		{oe[0], inv[0]} = 2'b10;
		gen(2, 1'b0, 16'h0009, 16'h0005, 16'h0003);
		dr[2] = 16'h0002;
		df[2] = 16'h0001;
		db[2] = 1'b1;
		repeat (30) @(negedge clk);
		run(100);
		chk("band first high", 30, hi[4]);
		chk("band second high", 40, hi[5]);
		chk("pair overlap", 0, ovl);
		db[2] = 1'b0;
		repeat (30) @(negedge clk);
		run(100);
		chk("free first high", 50, hi[4]);
		chk("free second high", 70, hi[5]);
		sm[1] = 1'b1;
		gen(1, 1'b0, 16'h0007, 16'h0002, 16'h0001);
		repeat (16) @(negedge clk);
		run(40);
		chk("held period ints", 8, ni[1]);
		su[1] = 1'b1;
		@(negedge clk);
		su[1] = 1'b0;
		repeat (16) @(negedge clk);
		run(40);
		chk("synced period ints", 5, ni[1]);
		gen(0, 1'b0, 16'h0003, 16'h0002, 16'h0001);
		{halt, pz[0]} = 2'b11;
		repeat (8) @(negedge clk);
		run(42);
		chk("paused ints", 0, ni[0]);
		chk("running gen ints", 6, ni[3]);
		pz[0] = 1'b0;
		repeat (8) @(negedge clk);
		run(40);
		chk("debug run ints", 10, ni[0]);
		{halt, mp_en, mp, fs[0], fl[0], trip} = {2'b01, 16'h0014, 3'b111};
		repeat (6) @(negedge clk);
		chk("fault drive level", 1, int'(wave[0] === 1'b1));
		chk("fault status bit", 1, int'(stat[4] === 1'b1));
		trip = 1'b0;
		run(40);
		chk("min fault period", 1, int'(nf >= 20 && nf <= 26));
		end_of_test();
	end
endmodule
`default_nettype wire
